// ---- dv/cps_fet_model.sv ----
module cps_fet_model (
    input wire logic aclk,
    input wire logic charge_gate_out,
    input wire logic discharge_gate_out,
    output logic chg_fet_on,
    output logic dis_fet_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // Gate charge takes time, so conduction lags the drive by one clock
    always_ff @(posedge aclk) begin
        chg_fet_on <= charge_gate_out;
        dis_fet_on <= discharge_gate_out;
    end
endmodule

// ---- dv/cps_top_sva.sv ----
module cps_top_sva #(
    parameter int unsigned SHORT_DELAY_CYC = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cps_pkg::cps_axi_req_s axi_req,
    input wire cps_pkg::cps_axi_rsp_s axi_rsp,
    input wire cps_pkg::cps_cmp_s cmp_raw,
    input wire logic charge_gate_out,
    input wire logic discharge_gate_out,
    input wire logic sleep_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import cps_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Slack of eight cycles covers the sync flops and a release step before a trip
    logic [15:0] short_cnt_q;
    logic [15:0] short_cnt_d;
    logic dis_cause;
    logic chg_cause;
    assign short_cnt_d = (cmp_raw.sense_above_short && !cmp_raw.cell_above_ovc_detect) ?
        short_cnt_q + 16'h1 : 16'h0;
    assign dis_cause = cmp_raw.sense_above_dis_oc || cmp_raw.sense_above_short ||
        !cmp_raw.cell_above_ovd_detect;
    assign chg_cause = cmp_raw.cell_above_ovc_detect || cmp_raw.sense_below_chg_oc;
    always_ff @(posedge aclk) begin
        short_cnt_q <= aresetn ? short_cnt_d : 16'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    power_up_gates_a: assert property ($rose(aresetn) |-> charge_gate_out &&
        discharge_gate_out && !sleep_req) else $error("gates wrong after reset");
    sleep_gate_a: assert property (sleep_req |-> !discharge_gate_out)
        else $error("sleep with discharge gate on");
    dis_cause_a: assert property ($fell(discharge_gate_out) |-> $past(dis_cause, 3))
        else $error("discharge gate opened without cause");
    chg_cause_a: assert property ($fell(charge_gate_out) |-> $past(chg_cause, 3))
        else $error("charge gate opened without cause");
    short_trip_a: assert property (short_cnt_q >= SHORT_DELAY_CYC + 8 |->
        !discharge_gate_out) else $error("load short not acted on");
    keep_sleep_a: assert property ((sleep_req && !cmp_raw.charger_present) [*3] |=>
        sleep_req) else $error("sleep left without charger");
    write_resp_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
        axi_rsp.wready |=> axi_rsp.bvalid) else $error("write response late");
    read_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read response late");
    read_busy_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read accepted while busy");
    cover property ($rose(sleep_req));
    cover property ($fell(discharge_gate_out));
    cover property ($fell(charge_gate_out));
endmodule

bind cps_top cps_top_sva #(.SHORT_DELAY_CYC(SHORT_DELAY_CYC)) u_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .cmp_raw(cmp_raw),
    .charge_gate_out(charge_gate_out),
    .discharge_gate_out(discharge_gate_out),
    .sleep_req(sleep_req)
);

// ---- dv/cps_top_tb.sv ----
module cps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cps_pkg::*;
    typedef struct packed {logic [10:0] cmp; logic [7:0] cyc; logic [2:0] exp;} cps_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    cps_axi_req_s req = '0;
    cps_axi_rsp_s rsp;
    cps_cmp_s cmp = 11'h184;
    logic cg, dg, sl, chg_fet, dis_fet;
    logic [31:0] rd;
    logic [1:0] rs;
    int n_fail = 0;
    int checked = 0;
    // Comparator word, hold cycles, expected {charge, discharge, sleep}
    cps_row_s rows [27] = '{
        {11'h184, 8'h3c, 3'h6}, {11'h1c0, 8'h3c, 3'h4}, {11'h184, 8'h0a, 3'h6},
        {11'h1e0, 8'h12, 3'h4}, {11'h18a, 8'h0a, 3'h6}, {11'h19a, 8'h3c, 3'h2},
        {11'h186, 8'h0a, 3'h2}, {11'h184, 8'h0a, 3'h6}, {11'h784, 8'h3c, 3'h2},
        {11'h7e0, 8'h3c, 3'h2}, {11'h3e0, 8'h3c, 3'h4}, {11'h184, 8'h0a, 3'h6},
        {11'h784, 8'h3c, 3'h2}, {11'h384, 8'h0a, 3'h2}, {11'h184, 8'h0a, 3'h6},
        {11'h004, 8'h3c, 3'h5}, {11'h784, 8'h14, 3'h5}, {11'h11a, 8'h0a, 3'h5},
        {11'h19a, 8'h0a, 3'h6}, {11'h004, 8'h3c, 3'h5}, {11'h106, 8'h0a, 3'h6},
        {11'h01b, 8'h3c, 3'h5}, {11'h11b, 8'h0a, 3'h6}, {11'h1c0, 8'h0f, 3'h6},
        {11'h184, 8'h02, 3'h6}, {11'h1c0, 8'h0f, 3'h6}, {11'h184, 8'h0a, 3'h6}};
    always #25 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Short delays keep the run brief; every expectation above assumes these
    cps_top #(.OVERCHARGE_DELAY_CYC(40), .OVERDISCHARGE_DELAY_CYC(30), .DIS_OC_DELAY_CYC(20),
        .CHG_OC_DELAY_CYC(25), .SHORT_DELAY_CYC(10)) dut (.aclk(aclk), .aresetn(aresetn),
        .axi_req(req), .axi_rsp(rsp), .cmp_raw(cmp), .charge_gate_out(cg),
        .discharge_gate_out(dg), .sleep_req(sl));
    cps_fet_model u_fet (.aclk(aclk), .charge_gate_out(cg), .discharge_gate_out(dg),
        .chg_fet_on(chg_fet), .dis_fet_on(dis_fet));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task give_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Trailing delay keeps two calls from driving one signal in a single step
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        // No cycle count is assumed; only the watchdog ends a stuck wait
        while (!(aw && w)) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        while (!rsp.bvalid) @(posedge aclk);
        r = rsp.bresp;
        req.bready <= 1'b0;
        #1;
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (!rsp.arready);
        req.arvalid <= 1'b0;
        while (!rsp.rvalid) @(posedge aclk);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk(32'h6, 32'({cg, dg, sl}));
        axi_rd(8'h00, rd, rs);
        chk(32'h1, 32'({rs, rd[0]}));
        axi_rd(8'h04, rd, rs);
        chk(32'h18, 32'({rs, rd[5:0]}));
        axi_wr(8'h04, 32'hff, rs);
        chk(32'h0, 32'(rs));
        axi_wr(8'h0c, 32'h1, rs);
        chk(32'h2, 32'(rs));
        axi_rd(8'h0c, rd, rs);
        chk(32'h2, 32'(rs));
        axi_wr(8'h00, 32'h0, rs);
        chk(32'h0, 32'(rs));
        axi_rd(8'h00, rd, rs);
        chk(32'h0, 32'({rs, rd[0]}));
        axi_wr(8'h00, 32'h1, rs);
        for (int i = 0; i < $size(rows); i++) begin
            cmp <= rows[i].cmp;
            repeat (rows[i].cyc) @(posedge aclk);
            #1;
            chk(32'(rows[i].exp), 32'({cg, dg, sl}));
            chk(32'(rows[i].exp[2:1]), 32'({chg_fet, dis_fet}));
        end
        // Every state was entered by the rows, so every entry flag stands until cleared
        axi_rd(8'h08, rd, rs);
        chk(32'h3f, 32'({rs, rd[5:0]}));
        axi_wr(8'h08, 32'h3f, rs);
        axi_rd(8'h08, rd, rs);
        chk(32'h0, 32'({rs, rd[5:0]}));
        // Zero-volt charging disabled: no session, so only the release level wakes it
        axi_wr(8'h00, 32'h0, rs);
        cmp <= 11'h01b;
        repeat (60) @(posedge aclk);
        #1;
        chk(32'h5, 32'({cg, dg, sl}));
        cmp <= 11'h11b;
        repeat (10) @(posedge aclk);
        #1;
        chk(32'h5, 32'({cg, dg, sl}));
        cmp <= 11'h19a;
        repeat (10) @(posedge aclk);
        #1;
        chk(32'h6, 32'({cg, dg, sl}));
        cmp <= 11'h784;
        repeat (60) @(posedge aclk);
        #1;
        chk(32'h2, 32'({cg, dg, sl}));
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk(32'h6, 32'({cg, dg, sl}));
        cmp <= 11'h184;
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
        #1;
        chk(32'h6, 32'({cg, dg, sl}));
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end
endmodule

// ---- verilog/cps_cfg.svh ----
// Summary of operation
// - Leave overcharge: sense low, cell below release
// - Leave overcharge: sense high, cell below detect
// - Ignore discharge faults while cell above overcharge
// - Long undervoltage in normal enters over-discharge
// - Over-discharge raises the sleep request
// - Charger, sense below limit: release at release
// - Charger, sense above limit: release at detect
// - No charger keeps over-discharge sleep
// - Long discharge overcurrent opens discharge gate
// - Long load short opens discharge gate
// - Sense back at or below ground releases
// - Long charge overcurrent opens charge gate
// - Charger gone, sense at ground releases
// - Zero-volt allowance forces charge gate on
// - Zero-volt cell above detect returns normal
// - Zero-volt charging beats charge-overcurrent detection
// - Normal state drives both gates on
// - Long overvoltage enters overcharge, charge gate off
// - Charge-overcurrent delay typically 15 ms
// - Load-short delay typically 300 us
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

`define CPS_ADDR_W 8
`define CPS_CLK_KHZ 20000
`define CPS_T_OVERCHARGE_MS 1300
`define CPS_T_OVERDISCHARGE_MS 145
`define CPS_T_DIS_OC_MS 12
`define CPS_T_CHG_OC_MS 15
`define CPS_T_SHORT_US 300

`define CPS_REG_CTRL 8'h00
`define CPS_REG_STATUS 8'h04
`define CPS_REG_EVENT 8'h08

`define CPS_CTRL_ZV_EN 0
`define CPS_CTRL_RST 32'h0000_0001
`define CPS_ST_STATE_LSB 0
`define CPS_ST_CHG_GATE 3
`define CPS_ST_DIS_GATE 4
`define CPS_ST_SLEEP 5
`define CPS_ST_ZV_ACTIVE 6
`define CPS_ST_CMP_LSB 16
`define CPS_EVENT_W 6

`define CPS_RESP_OKAY 2'h0
`define CPS_RESP_SLVERR 2'h2

`endif

// ---- verilog/cps_pkg.sv ----
`include "cps_cfg.svh"

package cps_pkg;

    typedef enum logic [2:0] {
        CPS_NORMAL = 3'b000,
        CPS_OVERCHARGE = 3'b001,
        CPS_OVERDISCHARGE = 3'b010,
        CPS_DIS_OVERCURRENT = 3'b011,
        CPS_LOAD_SHORT = 3'b100,
        CPS_CHG_OVERCURRENT = 3'b101
    } cps_state_e;

    // Comparator results, one bit each, true when the named condition holds
    typedef struct packed {
        logic cell_above_ovc_detect;
        logic cell_above_ovc_release;
        logic cell_above_ovd_detect;
        logic cell_above_ovd_release;
        logic sense_above_dis_oc;
        logic sense_above_short;
        logic sense_below_chg_oc;
        logic sense_below_vss;
        logic sense_at_vss;
        logic charger_present;
        logic zero_volt_charge_ok;
    } cps_cmp_s;

    typedef struct packed {
        logic [`CPS_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`CPS_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } cps_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cps_axi_rsp_s;

endpackage

// ---- verilog/cps_qual.sv ----
module cps_qual #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cond,
    output logic hit
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire at_end = (cnt_q == LAST);

    // Any dropout restarts the count, so only a continuous violation qualifies
    assign cnt_d = !cond ? '0 : (at_end ? cnt_q : cnt_q + W'(1));
    assign hit = cond && at_end;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- verilog/cps_top.sv ----
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`include "cps_cfg.svh"

module cps_top #(
    parameter int unsigned OVERCHARGE_DELAY_CYC = `CPS_T_OVERCHARGE_MS * `CPS_CLK_KHZ,
    parameter int unsigned OVERDISCHARGE_DELAY_CYC = `CPS_T_OVERDISCHARGE_MS * `CPS_CLK_KHZ,
    parameter int unsigned DIS_OC_DELAY_CYC = `CPS_T_DIS_OC_MS * `CPS_CLK_KHZ,
    parameter int unsigned CHG_OC_DELAY_CYC = `CPS_T_CHG_OC_MS * `CPS_CLK_KHZ,
    parameter int unsigned SHORT_DELAY_CYC = `CPS_T_SHORT_US * `CPS_CLK_KHZ / 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cps_pkg::cps_axi_req_s axi_req,
    output cps_pkg::cps_axi_rsp_s axi_rsp,
    input wire cps_pkg::cps_cmp_s cmp_raw,
    output logic charge_gate_out,
    output logic discharge_gate_out,
    output logic sleep_req
);
    import cps_pkg::*;

    localparam int NQ = 5;
    localparam int Q_SHORT = 0;
    localparam int Q_DIS_OC = 1;
    localparam int Q_OVD = 2;
    localparam int Q_OVC = 3;
    localparam int Q_CHG_OC = 4;
    localparam int unsigned QCYC [NQ] = '{
        SHORT_DELAY_CYC,
        DIS_OC_DELAY_CYC,
        OVERDISCHARGE_DELAY_CYC,
        OVERCHARGE_DELAY_CYC,
        CHG_OC_DELAY_CYC
    };

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchronisers

    cps_cmp_s sync1_q;
    cps_cmp_s cmp_q;

    // Comparators switch asynchronously to the timing clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            cmp_q <= '0;
        end else begin
            sync1_q <= cmp_raw;
            cmp_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Qualification delays

    cps_state_e state_q;
    cps_state_e state_d;
    logic [31:0] ctrl_q;
    logic zv_active_q;
    logic [NQ-1:0] q_cond;
    logic [NQ-1:0] q_hit;

    wire in_normal = (state_q == CPS_NORMAL);
    wire in_ovc = (state_q == CPS_OVERCHARGE);
    // Discharge faults are blind while the cell sits above overcharge detect
    wire dis_fault_ok = (in_normal || in_ovc) && !cmp_q.cell_above_ovc_detect;
    wire zv_en = ctrl_q[`CPS_CTRL_ZV_EN];
    // When enabled, zero-volt charging takes the charge gate whenever zero_volt_charge_ok holds and the cell is below overdischarge detect
    wire zv_force = zv_en && cmp_q.zero_volt_charge_ok
        && !cmp_q.cell_above_ovd_detect;

    assign q_cond[Q_SHORT] = dis_fault_ok && cmp_q.sense_above_short;
    assign q_cond[Q_DIS_OC] = dis_fault_ok && cmp_q.sense_above_dis_oc;
    assign q_cond[Q_OVD] = in_normal && !cmp_q.cell_above_ovd_detect;
    assign q_cond[Q_OVC] = in_normal && cmp_q.cell_above_ovc_detect;
    assign q_cond[Q_CHG_OC] = in_normal && cmp_q.sense_below_chg_oc
        && cmp_q.cell_above_ovd_detect;

    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi++) begin : g_qual
            cps_qual #(
                .CYCLES(QCYC[gi])
            ) u_qual (
                .aclk(aclk),
                .aresetn(aresetn),
                .cond(q_cond[gi]),
                .hit(q_hit[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Protection state machine

    wire ovc_release = (!cmp_q.sense_above_dis_oc && !cmp_q.cell_above_ovc_release)
        || (cmp_q.sense_above_dis_oc && !cmp_q.cell_above_ovc_detect);
    wire ovd_release = cmp_q.charger_present && (
        (!cmp_q.sense_below_chg_oc && cmp_q.cell_above_ovd_detect)
        || (cmp_q.sense_below_chg_oc && cmp_q.cell_above_ovd_release));
    // A zero-volt session ends only with the charger still there, never on a bare cell
    wire zv_release = zv_active_q && cmp_q.charger_present
        && cmp_q.cell_above_ovd_detect;
    wire dis_release = cmp_q.sense_at_vss || cmp_q.sense_below_vss;
    wire chg_release = !cmp_q.charger_present && cmp_q.sense_at_vss;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CPS_NORMAL: begin
                // Short has the shortest delay and the worst hazard, so it leads
                if (q_hit[Q_SHORT]) begin
                    state_d = CPS_LOAD_SHORT;
                end else if (q_hit[Q_DIS_OC]) begin
                    state_d = CPS_DIS_OVERCURRENT;
                end else if (q_hit[Q_OVD]) begin
                    state_d = CPS_OVERDISCHARGE;
                end else if (q_hit[Q_OVC]) begin
                    state_d = CPS_OVERCHARGE;
                end else if (q_hit[Q_CHG_OC]) begin
                    state_d = CPS_CHG_OVERCURRENT;
                end
            end
            CPS_OVERCHARGE: begin
                if (q_hit[Q_SHORT]) begin
                    state_d = CPS_LOAD_SHORT;
                end else if (q_hit[Q_DIS_OC]) begin
                    state_d = CPS_DIS_OVERCURRENT;
                end else if (ovc_release) begin
                    state_d = CPS_NORMAL;
                end
            end
            CPS_OVERDISCHARGE: begin
                // Without a charger nothing wakes it, not even a full cell
                if (ovd_release || zv_release) begin
                    state_d = CPS_NORMAL;
                end
            end
            CPS_DIS_OVERCURRENT, CPS_LOAD_SHORT: begin
                if (dis_release) begin
                    state_d = CPS_NORMAL;
                end
            end
            CPS_CHG_OVERCURRENT: begin
                if (chg_release) begin
                    state_d = CPS_NORMAL;
                end
            end
            default: begin
                state_d = CPS_NORMAL;
            end
        endcase
    end

    // Gates follow the next state so they move on the same edge as the state
    wire dis_gate_d = (state_d == CPS_NORMAL) || (state_d == CPS_OVERCHARGE)
        || (state_d == CPS_CHG_OVERCURRENT);
    wire chg_gate_d = zv_force || (state_d == CPS_NORMAL)
        || (state_d == CPS_OVERDISCHARGE) || (state_d == CPS_DIS_OVERCURRENT)
        || (state_d == CPS_LOAD_SHORT);
    wire zv_active_d = (state_d == CPS_OVERDISCHARGE) && (zv_active_q || zv_force);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= CPS_NORMAL;
            charge_gate_out <= 1'b1;
            discharge_gate_out <= 1'b1;
            sleep_req <= 1'b0;
            zv_active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            charge_gate_out <= chg_gate_d;
            discharge_gate_out <= dis_gate_d;
            sleep_req <= (state_d == CPS_OVERDISCHARGE);
            zv_active_q <= zv_active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags

    logic [`CPS_EVENT_W-1:0] event_q;
    logic [`CPS_EVENT_W-1:0] event_set;
    logic [`CPS_EVENT_W-1:0] event_clr;

    function automatic logic [`CPS_EVENT_W-1:0] state_bit(input cps_state_e s);
        state_bit = '0;
        state_bit[s] = 1'b1;
    endfunction

    assign event_set = (state_d != state_q) ? state_bit(state_d) : '0;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic aw_got_q;
    logic w_got_q;
    logic [`CPS_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire aw_hs = axi_req.awvalid && axi_rsp.awready;
    wire w_hs = axi_req.wvalid && axi_rsp.wready;
    wire ar_hs = axi_req.arvalid && axi_rsp.arready;
    wire have_aw = aw_got_q || aw_hs;
    wire have_w = w_got_q || w_hs;
    wire wr_fire = have_aw && have_w && !axi_rsp.bvalid;

    wire [`CPS_ADDR_W-1:0] wr_addr = aw_hs ? axi_req.awaddr : awaddr_q;
    wire [31:0] wr_data = w_hs ? axi_req.wdata : wdata_q;
    wire [3:0] wr_strb = w_hs ? axi_req.wstrb : wstrb_q;

    wire wr_ctrl = wr_fire && (wr_addr == `CPS_REG_CTRL);
    wire wr_event = wr_fire && (wr_addr == `CPS_REG_EVENT);
    wire wr_ok = (wr_addr == `CPS_REG_CTRL) || (wr_addr == `CPS_REG_EVENT)
        || (wr_addr == `CPS_REG_STATUS);

    assign event_clr = (wr_event && wr_strb[0]) ? wr_data[`CPS_EVENT_W-1:0] : '0;

    wire aw_got_d = have_aw && !wr_fire;
    wire w_got_d = have_w && !wr_fire;
    wire bvalid_d = wr_fire || (axi_rsp.bvalid && !axi_req.bready);
    wire rvalid_d = ar_hs || (axi_rsp.rvalid && !axi_req.rready);

    wire [31:0] status_word = {
        {(16 - $bits(cps_cmp_s)){1'b0}}, cmp_q,
        9'h000, zv_active_q, sleep_req, discharge_gate_out, charge_gate_out, state_q
    };
    wire rd_ctrl = (axi_req.araddr == `CPS_REG_CTRL);
    wire rd_status = (axi_req.araddr == `CPS_REG_STATUS);
    wire rd_event = (axi_req.araddr == `CPS_REG_EVENT);
    wire rd_ok = rd_ctrl || rd_status || rd_event;
    wire [31:0] rd_word = rd_ctrl ? ctrl_q
        : rd_status ? status_word
        : rd_event ? {{(32 - `CPS_EVENT_W){1'b0}}, event_q}
        : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            ctrl_q <= `CPS_CTRL_RST;
            event_q <= '0;
            axi_rsp <= '0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            if (aw_hs) begin
                awaddr_q <= axi_req.awaddr;
            end
            if (w_hs) begin
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end
            if (wr_ctrl && wr_strb[0]) begin
                ctrl_q[`CPS_CTRL_ZV_EN] <= wr_data[`CPS_CTRL_ZV_EN];
            end
            // A new entry in the clearing cycle survives
            event_q <= (event_q & ~event_clr) | event_set;
            axi_rsp.awready <= !aw_got_d && !bvalid_d;
            axi_rsp.wready <= !w_got_d && !bvalid_d;
            axi_rsp.bvalid <= bvalid_d;
            if (wr_fire) begin
                axi_rsp.bresp <= wr_ok ? `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
            end
            axi_rsp.arready <= !rvalid_d;
            axi_rsp.rvalid <= rvalid_d;
            if (ar_hs) begin
                axi_rsp.rdata <= rd_word;
                axi_rsp.rresp <= rd_ok ? `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
            end
        end
    end
endmodule
